// ### src/uart_fmt_pkg.sv
// constants and field layout for the uart fifo and line format block
// How it works
// R01 - receive store is 64-byte fifo from shifter
// R02 - fifo off: receive uses entry 0 only
// R03 - each receive entry keeps its error bits
// R04 - transmit store is 64-byte fifo to shifter
// R05 - fifo off: transmit uses entry 0 only
// R06 - full fifo drops new characters, no stall
// R07 - fifo control write-only; reads give status
// R08 - control bit 0 enables both fifos
// R09 - control bit 1 clears receive fifo
// R10 - control bit 2 clears transmit fifo
// R11 - control bit 3 picks dma mode
// R12 - bits 5:4 pick transmit free-space trigger
// R13 - transmit trigger writable only with enhanced enable
// R14 - bits 7:6 pick receive character trigger
// R15 - line bits 1:0 give word length
// R16 - line bit 2 gives extra stop bits
// R17 - line bit 3 enables parity send/check
// R18 - line bit 4 picks odd or even
// R19 - line bit 5 forces fixed parity value
// R20 - line bit 6 holds transmit line low
// R21 - line bit 7 maps divisor latches
// R22 - level registers need enhanced and modem bit 6
// R23 - key 0xbf exposes enhanced and flow chars
// R24 - enhanced-only bits need enhanced enable bit
package uart_fmt_pkg;
    // register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_FIFO = 3'h2;
    localparam logic [2:0] OFS_LINE = 3'h3;
    localparam logic [2:0] OFS_MODEM = 3'h4;
    localparam logic [2:0] OFS_LSTAT = 3'h5;
    localparam logic [2:0] OFS_MSTAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;
    // field positions
    localparam int LC_STOP = 2;
    localparam int LC_PEN = 3;
    localparam int LC_EVEN = 4;
    localparam int LC_FORCE = 5;
    localparam int LC_BREAK = 6;
    localparam int LC_DLAB = 7;
    localparam int FC_EN = 0;
    localparam int FC_RXCLR = 1;
    localparam int FC_TXCLR = 2;
    localparam int FC_DMA = 3;
    localparam int EF_ENH = 4;
    localparam int MC_RDY = 2;
    localparam int MC_LOOP = 4;
    localparam int MC_LVL = 6;
    // keys and reset values
    localparam logic [7:0] LINE_KEY = 8'hbf;
    localparam logic [7:0] LINE_RST = 8'h19;
    localparam logic [7:0] ONES_RST = 8'hff;
    localparam logic [7:0] XON2_RST = 8'hef;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [5:0] IIR_NONE = 6'h01;
    // fifo sizing and trigger levels
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [6:0] RX_TRIG_0 = 7'h01;
    localparam logic [6:0] RX_TRIG_1 = 7'h04;
    localparam logic [6:0] RX_TRIG_2 = 7'h38;
    localparam logic [6:0] RX_TRIG_3 = 7'h3c;
    localparam logic [6:0] TX_TRIG_0 = 7'h08;
    localparam logic [6:0] TX_TRIG_1 = 7'h10;
    localparam logic [6:0] TX_TRIG_2 = 7'h20;
    localparam logic [6:0] TX_TRIG_3 = 7'h38;
    // oversampling: ticks per bit, mid-start sample, stop lengths
    localparam logic [5:0] TICK_LAST = 6'h0f;
    localparam logic [5:0] TICK_MID = 6'h07;
    localparam logic [5:0] STOP_ONE = 6'h0f;
    localparam logic [5:0] STOP_HALF = 6'h17;
    localparam logic [5:0] STOP_TWO = 6'h1f;
    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ser_t;
endpackage

// ### src/uart_fifo_line_format.sv
// one uart channel: holding fifos, shifters, fifo and line control
`timescale 1ns/1ps
module uart_fifo_line_format import uart_fmt_pkg::*; (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // parallel register port (pins)
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE_N,
    // serial line
    input wire logic RX,
    output logic TX,
    // dma request pins
    output logic RXRDY_N,
    output logic TXRDY_N
);
    // pin synchronisers; stage one feeds stage two only
    logic cs1_ff, rd1_ff, wr1_ff, rx1_ff;
    logic cs2_ff, rd2_ff, wr2_ff, rx2_ff, rd3_ff, wr3_ff;
    logic [2:0] a1_ff, a2_ff;
    logic [7:0] d1_ff, d2_ff;
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            {cs1_ff, rd1_ff, wr1_ff, rx1_ff} <= 4'hf;
            {cs2_ff, rd2_ff, wr2_ff, rx2_ff} <= 4'hf;
            {rd3_ff, wr3_ff} <= 2'h3;
            a1_ff <= 3'h0;
            a2_ff <= 3'h0;
            d1_ff <= 8'h00;
            d2_ff <= 8'h00;
        end else begin
            {cs1_ff, rd1_ff, wr1_ff, rx1_ff} <= {CS_N, RD_N, WR_N, RX};
            {cs2_ff, rd2_ff, wr2_ff, rx2_ff} <= {cs1_ff, rd1_ff, wr1_ff, rx1_ff};
            {rd3_ff, wr3_ff} <= {rd2_ff, wr2_ff};
            a1_ff <= ADDR;
            a2_ff <= a1_ff;
            d1_ff <= D_IN;
            d2_ff <= d1_ff;
        end
    end
    // a strobe acts once, on its falling edge with chip select low
    logic rd_go, wr_go;
    assign rd_go = rd3_ff && !rd2_ff && !cs2_ff;
    assign wr_go = wr3_ff && !wr2_ff && !cs2_ff;

    // control registers
    logic [7:0] lcr_ff, efr_ff, mcr_ff, ier_ff, spr_ff, div_lo_ff, div_hi_ff;
    logic [7:0] xon1_ff, xon2_ff, xoff_char_one_ff, xoff_char_two_ff, tcr_ff, tlr_ff;
    logic fifo_en_ff, dma_mode_ff;
    logic [1:0] tx_trig_ff, rx_trig_ff;
    logic key_open, lvl_open, dlab;

    // level registers open only with enhanced and modem bit 6
    function automatic logic level_access(input logic [7:0] enhanced_feature_reg,
                                          input logic [7:0] modem_control_reg);
        return enhanced_feature_reg[EF_ENH] && modem_control_reg[MC_LVL];
    endfunction
    assign key_open = (lcr_ff == LINE_KEY); // R23
    assign lvl_open = level_access(efr_ff, mcr_ff); // R22
    assign dlab = lcr_ff[LC_DLAB];

    logic wr_fifo_ctl;
    assign wr_fifo_ctl = wr_go && a2_ff == OFS_FIFO && !key_open && !dlab;

    // register writes; enhanced-only fields stay put unless enabled
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            lcr_ff <= LINE_RST;
            {efr_ff, mcr_ff, ier_ff, tcr_ff, tlr_ff} <= 40'h0;
            {div_lo_ff, div_hi_ff} <= 16'h0;
            {spr_ff, xon1_ff, xoff_char_one_ff, xoff_char_two_ff} <= 32'hffff_ffff;
            xon2_ff <= XON2_RST;
        end else if (wr_go) begin
            unique case (a2_ff)
                OFS_DATA: if (dlab) div_lo_ff <= d2_ff; // R21
                OFS_IER: begin
                    if (dlab) div_hi_ff <= d2_ff; // R21
                    else if (efr_ff[EF_ENH]) ier_ff <= d2_ff; // R24
                    else ier_ff[3:0] <= d2_ff[3:0];
                end
                OFS_FIFO: if (key_open) efr_ff <= d2_ff; // R23
                OFS_LINE: lcr_ff <= d2_ff;
                OFS_MODEM: begin
                    if (key_open) xon1_ff <= d2_ff; // R23
                    else if (efr_ff[EF_ENH]) mcr_ff <= d2_ff; // R24
                    else mcr_ff[4:0] <= d2_ff[4:0];
                end
                OFS_LSTAT: if (key_open) xon2_ff <= d2_ff;
                OFS_MSTAT: begin
                    if (key_open) xoff_char_one_ff <= d2_ff; // R23
                    else if (lvl_open) tcr_ff <= d2_ff; // R22
                end
                OFS_SCRATCH: begin
                    if (key_open) xoff_char_two_ff <= d2_ff; // R23
                    else if (lvl_open) tlr_ff <= d2_ff; // R22
                    else spr_ff <= d2_ff;
                end
            endcase
        end
    end

    // fifo control fields; the register itself is never read back
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            fifo_en_ff <= 1'b0;
            dma_mode_ff <= 1'b0;
            tx_trig_ff <= 2'h0;
            rx_trig_ff <= 2'h0;
        end else if (wr_fifo_ctl) begin
            fifo_en_ff <= d2_ff[FC_EN]; // R08
            dma_mode_ff <= d2_ff[FC_DMA]; // R11
            rx_trig_ff <= d2_ff[7:6]; // R14
            if (efr_ff[EF_ENH]) tx_trig_ff <= d2_ff[5:4]; // R13 R24
        end
    end
    // clear strobes act for one cycle, so the bits read as self-clearing
    logic rx_clr, tx_clr;
    assign rx_clr = wr_fifo_ctl && (d2_ff[FC_RXCLR] ||
                    d2_ff[FC_EN] != fifo_en_ff); // R09
    assign tx_clr = wr_fifo_ctl && (d2_ff[FC_TXCLR] ||
                    d2_ff[FC_EN] != fifo_en_ff); // R10

    // baud: one oversample tick every divisor cycles, zero treated as one
    logic [15:0] baud_cnt_ff, div_m1;
    logic tick;
    assign div_m1 = ({div_hi_ff, div_lo_ff} == 16'h0) ? 16'h0 :
                    {div_hi_ff, div_lo_ff} - 16'h1;
    assign tick = (baud_cnt_ff >= div_m1);
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) baud_cnt_ff <= 16'h0;
        else baud_cnt_ff <= tick ? 16'h0 : baud_cnt_ff + 16'h1;
    end

    // word length and parity shared by both shifters; mask used by transmit only
    logic [3:0] last_bit;
    logic [7:0] len_mask;
    assign last_bit = {2'b01, lcr_ff[1:0]} ; // R15: 4..7 = five..eight bits
    assign len_mask = 8'hff >> (3'h3 - {1'b0, lcr_ff[1:0]});
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [7:0] lc);
        if (lc[LC_FORCE]) return !lc[LC_EVEN]; // R19
        return lc[LC_EVEN] ? ^d : ~^d; // R18
    endfunction

    // receive shifter
    ser_t rx_st_ff;
    logic [5:0] rx_tk_ff;
    logic [3:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic rx_pbad_ff, rx_pzero_ff, rx_push;
    logic [10:0] rx_word;
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            rx_st_ff <= S_IDLE;
            rx_tk_ff <= 6'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 8'h0;
            rx_pbad_ff <= 1'b0;
            rx_pzero_ff <= 1'b1;
        end else if (rx_st_ff == S_IDLE) begin
            rx_tk_ff <= 6'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 8'h0;
            rx_pbad_ff <= 1'b0;
            rx_pzero_ff <= 1'b1;
            if (!rx2_ff) rx_st_ff <= S_START;
        end else if (tick) begin
            rx_tk_ff <= rx_tk_ff + 6'h1;
            unique case (rx_st_ff)
                S_START: if (rx_tk_ff == TICK_MID) begin
                    rx_tk_ff <= 6'h0; // false start drops back to idle
                    rx_st_ff <= rx2_ff ? S_IDLE : S_DATA;
                end
                S_DATA: if (rx_tk_ff == TICK_LAST) begin
                    rx_tk_ff <= 6'h0;
                    rx_sh_ff[rx_bit_ff[2:0]] <= rx2_ff; // R01
                    rx_bit_ff <= rx_bit_ff + 4'h1;
                    if (rx_bit_ff == last_bit) // R15
                        rx_st_ff <= lcr_ff[LC_PEN] ? S_PAR : S_STOP; // R17
                end
                S_PAR: if (rx_tk_ff == TICK_LAST) begin
                    rx_tk_ff <= 6'h0;
                    rx_pzero_ff <= !rx2_ff;
                    rx_pbad_ff <= rx2_ff != par_of(rx_sh_ff, lcr_ff); // R17
                    rx_st_ff <= S_STOP;
                end
                S_STOP: if (rx_tk_ff == TICK_LAST) rx_st_ff <= S_IDLE;
                default: rx_st_ff <= S_IDLE;
            endcase
        end
    end
    assign rx_push = tick && rx_st_ff == S_STOP && rx_tk_ff == TICK_LAST;
    // entry = {break, framing, parity, data}, break needs all-low frame
    assign rx_word = {rx_sh_ff == 8'h0 && rx_pzero_ff && !rx2_ff,
                      !rx2_ff, rx_pbad_ff, rx_sh_ff}; // R03

    // receive fifo; with fifos off it holds one word in entry 0
    logic [10:0] rx_mem [0:63];
    logic [5:0] rx_wp_ff, rx_rp_ff;
    logic [6:0] rx_cnt_ff, rx_err_ff;
    logic rx_full, rx_pop, rx_ins, ovr_ff;
    logic [10:0] rx_head;
    assign rx_full = fifo_en_ff ? rx_cnt_ff == FIFO_DEPTH
                                : rx_cnt_ff != 7'h0; // R02
    assign rx_ins = rx_push && !rx_full; // R06
    assign rx_pop = rd_go && a2_ff == OFS_DATA && !dlab && rx_cnt_ff != 7'h0;
    assign rx_head = rx_mem[fifo_en_ff ? rx_rp_ff : 6'h0];
    always_ff @(posedge CORE_CLK) begin
        if (rx_ins) rx_mem[fifo_en_ff ? rx_wp_ff : 6'h0] <= rx_word; // R02
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || rx_clr) begin
            rx_wp_ff <= 6'h0; // R09
            rx_rp_ff <= 6'h0;
            rx_cnt_ff <= 7'h0;
            rx_err_ff <= 7'h0;
        end else begin
            if (rx_ins) rx_wp_ff <= fifo_en_ff ? rx_wp_ff + 6'h1 : 6'h0;
            if (rx_pop) rx_rp_ff <= fifo_en_ff ? rx_rp_ff + 6'h1 : 6'h0;
            rx_cnt_ff <= rx_cnt_ff + {6'h0, rx_ins} - {6'h0, rx_pop};
            rx_err_ff <= rx_err_ff + {6'h0, rx_ins && |rx_word[10:8]}
                         - {6'h0, rx_pop && |rx_head[10:8]};
        end
    end
    // overrun sticks until the line status is read; a new one wins
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) ovr_ff <= 1'b0;
        else if (rx_push && rx_full) ovr_ff <= 1'b1; // R06
        else if (rd_go && a2_ff == OFS_LSTAT && !key_open) ovr_ff <= 1'b0;
    end

    // transmit fifo; a write into a full store is dropped
    logic [7:0] tx_mem [0:63];
    logic [5:0] tx_wp_ff, tx_rp_ff;
    logic [6:0] tx_cnt_ff;
    logic tx_full, tx_ins, tx_take;
    assign tx_full = fifo_en_ff ? tx_cnt_ff == FIFO_DEPTH
                                : tx_cnt_ff != 7'h0; // R05
    assign tx_ins = wr_go && a2_ff == OFS_DATA && !dlab && !tx_full; // R06
    always_ff @(posedge CORE_CLK) begin
        if (tx_ins) tx_mem[fifo_en_ff ? tx_wp_ff : 6'h0] <= d2_ff; // R04
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || tx_clr) begin
            tx_wp_ff <= 6'h0; // R10
            tx_rp_ff <= 6'h0;
            tx_cnt_ff <= 7'h0;
        end else begin
            if (tx_ins) tx_wp_ff <= fifo_en_ff ? tx_wp_ff + 6'h1 : 6'h0;
            if (tx_take) tx_rp_ff <= fifo_en_ff ? tx_rp_ff + 6'h1 : 6'h0;
            tx_cnt_ff <= tx_cnt_ff + {6'h0, tx_ins} - {6'h0, tx_take};
        end
    end

    // two-entry buffer to the shifter; a full buffer stalls the fifo pop
    logic [7:0] tb_mem_ff [0:1];
    logic tb_wp_ff, tb_rp_ff, tb_in_ready, tb_out_valid, tb_out_ready;
    logic [1:0] tb_cnt_ff;
    assign tb_in_ready = tb_cnt_ff != 2'h2;
    assign tb_out_valid = tb_cnt_ff != 2'h0;
    assign tx_take = tx_cnt_ff != 7'h0 && tb_in_ready;
    always_ff @(posedge CORE_CLK) begin
        if (tx_take) tb_mem_ff[tb_wp_ff] <= 
            tx_mem[fifo_en_ff ? tx_rp_ff : 6'h0];
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || tx_clr) begin
            tb_wp_ff <= 1'b0;
            tb_rp_ff <= 1'b0;
            tb_cnt_ff <= 2'h0;
        end else begin
            if (tx_take) tb_wp_ff <= !tb_wp_ff;
            if (tb_out_valid && tb_out_ready) tb_rp_ff <= !tb_rp_ff;
            tb_cnt_ff <= tb_cnt_ff + {1'b0, tx_take}
                         - {1'b0, tb_out_valid && tb_out_ready};
        end
    end

    // transmit shifter
    ser_t tx_st_ff;
    logic [5:0] tx_tk_ff, stop_end;
    logic [3:0] tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic tx_par_ff, tx_bitval;
    assign tb_out_ready = tx_st_ff == S_IDLE;
    // one stop bit, else 1.5 for five-bit words and two otherwise
    assign stop_end = !lcr_ff[LC_STOP] ? STOP_ONE :
                      (lcr_ff[1:0] == 2'h0 ? STOP_HALF : STOP_TWO); // R16
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            tx_st_ff <= S_IDLE;
            tx_tk_ff <= 6'h0;
            tx_bit_ff <= 4'h0;
            tx_sh_ff <= 8'h0;
            tx_par_ff <= 1'b0;
        end else if (tx_st_ff == S_IDLE) begin
            tx_tk_ff <= 6'h0;
            tx_bit_ff <= 4'h0;
            if (tb_out_valid) begin
                tx_sh_ff <= tb_mem_ff[tb_rp_ff] & len_mask; // R04
                tx_par_ff <= par_of(tb_mem_ff[tb_rp_ff] & len_mask, lcr_ff);
                tx_st_ff <= S_START;
            end
        end else if (tick) begin
            tx_tk_ff <= tx_tk_ff + 6'h1;
            unique case (tx_st_ff)
                S_START: if (tx_tk_ff == TICK_LAST) begin
                    tx_tk_ff <= 6'h0;
                    tx_st_ff <= S_DATA;
                end
                S_DATA: if (tx_tk_ff == TICK_LAST) begin
                    tx_tk_ff <= 6'h0;
                    tx_sh_ff <= tx_sh_ff >> 1;
                    tx_bit_ff <= tx_bit_ff + 4'h1;
                    if (tx_bit_ff == last_bit) // R15
                        tx_st_ff <= lcr_ff[LC_PEN] ? S_PAR : S_STOP; // R17
                end
                S_PAR: if (tx_tk_ff == TICK_LAST) begin
                    tx_tk_ff <= 6'h0;
                    tx_st_ff <= S_STOP;
                end
                S_STOP: if (tx_tk_ff == stop_end) tx_st_ff <= S_IDLE; // R16
                default: tx_st_ff <= S_IDLE;
            endcase
        end
    end
    always_comb begin
        unique case (tx_st_ff)
            S_START: tx_bitval = 1'b0;
            S_DATA: tx_bitval = tx_sh_ff[0];
            S_PAR: tx_bitval = tx_par_ff; // R17
            default: tx_bitval = 1'b1;
        endcase
    end

    // trigger decodes and dma ready levels
    function automatic logic [6:0] rx_level(input logic [1:0] s);
        unique case (s)
            2'h0: return RX_TRIG_0;
            2'h1: return RX_TRIG_1;
            2'h2: return RX_TRIG_2;
            2'h3: return RX_TRIG_3;
        endcase
    endfunction
    function automatic logic [6:0] tx_level(input logic [1:0] s);
        unique case (s)
            2'h0: return TX_TRIG_0;
            2'h1: return TX_TRIG_1;
            2'h2: return TX_TRIG_2;
            2'h3: return TX_TRIG_3;
        endcase
    endfunction
    logic rx_ready, tx_ready;
    // mode 0 signals per character, mode 1 waits for the trigger level
    assign rx_ready = dma_mode_ff ? rx_cnt_ff >= rx_level(rx_trig_ff)
                                  : rx_cnt_ff != 7'h0; // R11 R14
    assign tx_ready = dma_mode_ff ? (FIFO_DEPTH - tx_cnt_ff) >=
                                    tx_level(tx_trig_ff)
                                  : tx_cnt_ff == 7'h0; // R11 R12

    // read mux; status words built from live state
    logic [7:0] lsr, rd_data;
    logic tx_idle_all;
    assign tx_idle_all = tx_cnt_ff == 7'h0 && !tb_out_valid &&
                         tx_st_ff == S_IDLE;
    assign lsr = {rx_err_ff != 7'h0, tx_idle_all, tx_cnt_ff == 7'h0,
                  rx_head[10:8] & {3{rx_cnt_ff != 7'h0}},
                  ovr_ff, rx_cnt_ff != 7'h0};
    always_comb begin
        unique case (a2_ff)
            OFS_DATA: rd_data = dlab ? div_lo_ff : rx_head[7:0];
            OFS_IER: rd_data = dlab ? div_hi_ff : ier_ff;
            OFS_FIFO: rd_data = key_open ? efr_ff
                              : {fifo_en_ff, fifo_en_ff, IIR_NONE}; // R07
            OFS_LINE: rd_data = lcr_ff;
            OFS_MODEM: rd_data = key_open ? xon1_ff : mcr_ff;
            OFS_LSTAT: rd_data = key_open ? xon2_ff : lsr;
            OFS_MSTAT: rd_data = key_open ? xoff_char_one_ff
                               : (lvl_open ? tcr_ff : ZERO_BYTE); // R22
            OFS_SCRATCH: begin
                if (key_open) rd_data = xoff_char_two_ff;
                else if (lvl_open) rd_data = tlr_ff; // R22
                else if (mcr_ff[MC_RDY] && !mcr_ff[MC_LOOP])
                    rd_data = {3'h0, rx_ready, 3'h0, tx_ready};
                else rd_data = spr_ff;
            end
        endcase
    end

    // registered outputs; data drives while read and select are low
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            D_OUT <= 8'h00;
            D_OE_N <= 1'b1;
            TX <= 1'b1;
            RXRDY_N <= 1'b1;
            TXRDY_N <= 1'b1;
        end else begin
            if (rd_go) D_OUT <= rd_data;
            D_OE_N <= rd2_ff || cs2_ff;
            TX <= lcr_ff[LC_BREAK] ? 1'b0 : tx_bitval; // R20
            RXRDY_N <= !rx_ready;
            TXRDY_N <= !tx_ready;
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    property p_break_low;
        lcr_ff[LC_BREAK] |=> !TX;
    endproperty
    a_break_low: assert property (p_break_low) // R20
        else $error("break not holding tx low");
    property p_rx_drop;
        rx_push && rx_full && !rx_pop && !rx_clr |=> $stable(rx_cnt_ff);
    endproperty
    a_rx_drop: assert property (p_rx_drop) // R06
        else $error("full receive fifo changed on drop");
    property p_rx_clear;
        rx_clr |=> rx_cnt_ff == 7'h0 && rx_err_ff == 7'h0;
    endproperty
    a_rx_clear: assert property (p_rx_clear) // R09
        else $error("receive fifo not cleared");
    property p_tx_clear;
        tx_clr |=> tx_cnt_ff == 7'h0 ##1 tb_cnt_ff == 2'h0;
    endproperty
    a_tx_clear: assert property (p_tx_clear) // R10
        else $error("transmit fifo not cleared");
    property p_fctl_hidden;
        rd_go && a2_ff == OFS_FIFO && !key_open |=>
            D_OUT[5:0] == IIR_NONE && D_OUT[7] == fifo_en_ff;
    endproperty
    a_fctl_hidden: assert property (p_fctl_hidden) // R07
        else $error("fifo control read back");
    property p_single_entry;
        !fifo_en_ff |-> rx_cnt_ff <= 7'h1 && tx_cnt_ff <= 7'h1;
    endproperty
    a_single_entry: assert property (p_single_entry) // R02
        else $error("disabled fifo holds more than one");
    property p_trig_lock;
        wr_fifo_ctl && !efr_ff[EF_ENH] |=> $stable(tx_trig_ff);
    endproperty
    a_trig_lock: assert property (p_trig_lock) // R13
        else $error("tx trigger changed without enhanced enable");
    property p_dlab_read;
        rd_go && a2_ff == OFS_DATA && dlab |=> D_OUT == $past(div_lo_ff);
    endproperty
    a_dlab_read: assert property (p_dlab_read) // R21
        else $error("divisor latch not mapped");
    property p_key_write;
        wr_go && a2_ff == OFS_FIFO && key_open |=> efr_ff == $past(d2_ff);
    endproperty
    a_key_write: assert property (p_key_write) // R23
        else $error("enhanced register not written under key");
endmodule // uart_fifo_line_format

// ### testbench/uart_host_model.sv
// host processor model driving the parallel register pins
`timescale 1ns/1ps
module uart_host_model (
    // clock and read data
    input wire logic clk,
    input wire logic [7:0] d_out,
    input wire logic d_oe_n,
    // strobes and bus
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [2:0] addr,
    output logic [7:0] d_in
);
    initial begin
        {cs_n, rd_n, wr_n} = 3'h7;
        addr = 3'h0;
        d_in = 8'h00;
    end

    // pins are synced inside, so setup and strobe width span several clocks
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk) #1;
        addr = a;
        d_in = d;
        cs_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rd_n = w;
        wr_n = !w;
        repeat (6) @(posedge clk);
        // an undriven bus reads back inverted, so a missing enable shows
        #1 q = d_oe_n ? ~d_out : d_out;
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 cs_n = 1'b1;
    endtask
endmodule // uart_host_model

// ### testbench/tb_top.sv
// self-checking bench for the uart fifo and line format block
`timescale 1ns/1ps
module tb_top import uart_fmt_pkg::*; ;
    logic core_clk, rst_n, cs_n, rd_n, wr_n, d_oe_n, tx, rxrdy_n, txrdy_n;
    logic [2:0] addr;
    logic [7:0] d_in, d_out, q;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    // serial line looped straight back so both shifters meet
    uart_fifo_line_format u_uart_fifo_line_format (.CORE_CLK(core_clk),
        .RESET_N(rst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE_N(d_oe_n),
        .RX(tx), .TX(tx), .RXRDY_N(rxrdy_n), .TXRDY_N(txrdy_n));
    uart_host_model u_host (.clk(core_clk), .d_out(d_out), .d_oe_n(d_oe_n),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .d_in(d_in));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        u_host.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // one 8n1 frame is 160 clocks at divisor zero
    task automatic send(input logic [7:0] d);
        wr(OFS_DATA, d);
        repeat (250) @(posedge core_clk);
    endtask

    // hang guard, far above the few thousand clocks needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rd(OFS_LINE, LINE_RST);
        rd(OFS_SCRATCH, ONES_RST);
        rd(OFS_FIFO, 8'h01);
        chk({7'h00, txrdy_n}, 8'h00);
        wr(OFS_LINE, 8'h03);
        // fifos off: second character finds entry 0 taken
        send(8'h11);
        send(8'h22);
        rd(OFS_LSTAT, 8'h63);
        rd(OFS_DATA, 8'h11);
        // fifos on, dma mode 1, receive trigger of four
        wr(OFS_FIFO, 8'h49);
        rd(OFS_FIFO, 8'hc1);
        for (int i = 0; i < 3; i++) send(8'ha0 + 8'(i));
        chk({7'h00, rxrdy_n}, 8'h01);
        send(8'ha3);
        chk({7'h00, rxrdy_n}, 8'h00);
        rd(OFS_DATA, 8'ha0);
        wr(OFS_FIFO, 8'h4b);
        rd(OFS_LSTAT, 8'h60);
        chk({7'h00, rxrdy_n}, 8'h01);
        wr(OFS_LINE, 8'h43);
        chk({7'h00, tx}, 8'h00);
        wr(OFS_LINE, 8'h03);
        chk({7'h00, tx}, 8'h01);
        // the break looks like a start bit; let that frame end, then flush
        repeat (250) @(posedge core_clk);
        wr(OFS_FIFO, 8'h4b);
        // seven bits, even parity: top bit must not arrive
        wr(OFS_LINE, 8'h1a);
        send(8'hd5);
        rd(OFS_LSTAT, 8'h61);
        rd(OFS_DATA, 8'h55);
        // divisor latch bank over data and enable addresses
        wr(OFS_LINE, 8'h83);
        wr(OFS_IER, 8'h0f);
        rd(OFS_IER, 8'h0f);
        rd(OFS_DATA, 8'h00);
        wr(OFS_IER, 8'h00);
        wr(OFS_LINE, 8'h03);
        rd(OFS_IER, 8'h00);
        wr(OFS_LINE, LINE_KEY);
        rd(OFS_MODEM, ONES_RST);
        wr(OFS_FIFO, 8'h10);
        rd(OFS_FIFO, 8'h10);
        wr(OFS_LINE, 8'h03);
        // enhanced on: modem bit 6 opens the level registers over scratch
        wr(OFS_MODEM, 8'h40);
        rd(OFS_MODEM, 8'h40);
        wr(OFS_SCRATCH, 8'h5a);
        rd(OFS_SCRATCH, 8'h5a);
        wr(OFS_MODEM, 8'h00);
        rd(OFS_SCRATCH, ONES_RST);
        conclude();
    end
endmodule // tb_top
